/* File: src/dpm_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"

// What this block does
// - Byte 0x9f holds code points 0x3f (bits 7-6) down to 0x3c (bits 1-0).
// - Byte 0x9e holds code points 0x3b (bits 7-6) down to 0x38 (bits 1-0).
// - Byte 0x9d holds code points 0x37 (bits 7-6) down to 0x34 (bits 1-0).
// - Byte 0x9c holds code points 0x33 (bits 7-6) down to 0x30 (bits 1-0); fields are RW, reset to 00.
// - A classified frame takes the map field picked by bits 7:2 of its service class byte.
// - Bit 2 of byte 0xa4 enables listener snooping when 1, disables it when 0, resets to 0.
// - Bit 3 of byte 0xa4 enables the snooping option when 1, disables it when 0, resets to 0.
// - Port control bit 6 lets the port pass all frames; resets to 0; only under rx sniffing.
// - Port control bytes sit at 0xb0, 0xc0, 0xd0, 0xf0 for ports 1 to 4; 0xe0 is reserved.
module dpm_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic class_valid,
  input wire logic [7:0] ip_service_class_byte,
  output logic class_done,
  output logic class_hit,
  output dpm_pkg::dpm_prio_t class_prio,
  output logic mld_snoop_en,
  output logic mld_snoop_option,
  output logic [2:0] hs_drive_strength,
  output logic [2:0] ls_drive_strength,
  input wire logic [3:0] rx_sniff_mirror,
  output logic [3:0] pass_all_frames
);

  dpm_pkg::dpm_apb_state_t state;
  dpm_pkg::dpm_apb_state_t next_state;

  dpm_pkg::dpm_byte_t map12;
  dpm_pkg::dpm_byte_t map13;
  dpm_pkg::dpm_byte_t map14;
  dpm_pkg::dpm_byte_t map15;
  logic [2:0] hs_drive;
  logic [2:0] ls_drive;
  logic mld_en;
  logic mld_opt;
  logic [3:0] pass_all;

  // bus decode
  wire [7:0] idx = paddr[9:2];
  wire addr_ok = (paddr[11:10] == 2'h0);
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr_done = done & pwrite & pstrb[0];

  wire hit_map12 = addr_ok & (idx == `DPM_IDX_MAP12);
  wire hit_map13 = addr_ok & (idx == `DPM_IDX_MAP13);
  wire hit_map14 = addr_ok & (idx == `DPM_IDX_MAP14);
  wire hit_map15 = addr_ok & (idx == `DPM_IDX_MAP15);
  wire hit_ctrl20 = addr_ok & (idx == `DPM_IDX_CTRL20);
  wire hit_ctrl21 = addr_ok & (idx == `DPM_IDX_CTRL21);
  wire hit_port1 = addr_ok & (idx == `DPM_IDX_PORT1);
  wire hit_port2 = addr_ok & (idx == `DPM_IDX_PORT2);
  wire hit_port3 = addr_ok & (idx == `DPM_IDX_PORT3);
  wire hit_port4 = addr_ok & (idx == `DPM_IDX_PORT4);
  wire hit_rsvd = addr_ok & (idx == `DPM_IDX_RSVD);
  wire [3:0] hit_port = {hit_port4, hit_port3, hit_port2, hit_port1};

  // the reserved port slot is still a mapped word, so it answers without error
  wire mapped = hit_map12 | hit_map13 | hit_map14 | hit_map15 | hit_ctrl20
    | hit_ctrl21 | (|hit_port) | hit_rsvd;

  wire [7:0] ctrl20_rd = {1'b0, hs_drive, 1'b0, ls_drive};
  wire [7:0] ctrl21_rd = {`DPM_CTRL21_RSVD_HI, mld_opt, mld_en, `DPM_CTRL21_RSVD_LO};

  function automatic logic [7:0] port_rd(input logic pass);
    port_rd = {`DPM_PORT_RSVD_B7, pass, 6'h00};
  endfunction : port_rd

  wire [7:0] rd_byte =
    hit_map12 ? map12 :
    hit_map13 ? map13 :
    hit_map14 ? map14 :
    hit_map15 ? map15 :
    hit_ctrl20 ? ctrl20_rd :
    hit_ctrl21 ? ctrl21_rd :
    hit_port1 ? port_rd(pass_all[0]) :
    hit_port2 ? port_rd(pass_all[1]) :
    hit_port3 ? port_rd(pass_all[2]) :
    hit_port4 ? port_rd(pass_all[3]) :
    8'h00;

  wire [7:0] wbyte = pwdata[7:0];

  // one wait-free access phase: answer is always given in the cycle after setup
  always_comb begin
    case (state)
      dpm_pkg::DPM_IDLE: next_state = setup ? dpm_pkg::DPM_ANSWER : dpm_pkg::DPM_IDLE;
      dpm_pkg::DPM_ANSWER: next_state = dpm_pkg::DPM_IDLE;
      default: next_state = dpm_pkg::DPM_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dpm_pkg::DPM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= (next_state == dpm_pkg::DPM_ANSWER);
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // dscp priority map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map12 <= `DPM_MAP_RESET;
      map13 <= `DPM_MAP_RESET;
      map14 <= `DPM_MAP_RESET;
      map15 <= `DPM_MAP_RESET;
    end else begin
      if (wr_done & hit_map12) map12 <= wbyte;
      if (wr_done & hit_map13) map13 <= wbyte;
      if (wr_done & hit_map14) map14 <= wbyte;
      if (wr_done & hit_map15) map15 <= wbyte;
    end
  end

  // global controls; reserved bits are not stored and read back fixed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_drive <= `DPM_HS_DRIVE_RESET;
      ls_drive <= `DPM_LS_DRIVE_RESET;
      mld_en <= 1'b0;
      mld_opt <= 1'b0;
    end else begin
      if (wr_done & hit_ctrl20) begin
        hs_drive <= wbyte[`DPM_HS_DRIVE_LSB +: 3];
        ls_drive <= wbyte[`DPM_LS_DRIVE_LSB +: 3];
      end
      if (wr_done & hit_ctrl21) begin
        mld_en <= wbyte[`DPM_MLD_EN_BIT];
        mld_opt <= wbyte[`DPM_MLD_OPT_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_all <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_done & hit_port[i]) pass_all[i] <= wbyte[`DPM_PASS_ALL_BIT];
      end
    end
  end

  // classification reads the map as it stood before this edge, so a write
  // landing on the same edge only affects the next frame
  wire [31:0] map_table = {map15, map14, map13, map12};
  wire cls_hit;
  dpm_pkg::dpm_prio_t cls_prio;

  dpm_classify u_classify (
    .map_table(map_table),
    .class_byte(ip_service_class_byte),
    .hit(cls_hit),
    .prio(cls_prio)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      class_done <= 1'b0;
      class_hit <= 1'b0;
      class_prio <= 2'h0;
    end else begin
      class_done <= class_valid;
      if (class_valid) begin
        class_hit <= cls_hit;
        class_prio <= cls_prio;
      end
    end
  end

  // control outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mld_snoop_en <= 1'b0;
      mld_snoop_option <= 1'b0;
      hs_drive_strength <= `DPM_HS_DRIVE_RESET;
      ls_drive_strength <= `DPM_LS_DRIVE_RESET;
      pass_all_frames <= 4'h0;
    end else begin
      mld_snoop_en <= mld_en;
      mld_snoop_option <= mld_opt;
      hs_drive_strength <= hs_drive;
      ls_drive_strength <= ls_drive;
      pass_all_frames <= pass_all & rx_sniff_mirror;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire [1:0] prio_ref = map_table[{ip_service_class_byte[5:2], 1'b0} +: 2];
  wire in_slice = (ip_service_class_byte[7:6] == 2'h3);

  sequence s_write(logic sel);
    wr_done && sel;
  endsequence

  sequence s_read_setup(logic sel);
    setup && !pwrite && sel;
  endsequence

  sequence s_answered;
    setup ##1 (psel && penable && pready);
  endsequence

  map15_write_a: assert property (s_write(hit_map15) |=> map15 == $past(pwdata[7:0]))
    else $error("map15 write not stored");
  map14_write_a: assert property (s_write(hit_map14) |=> map14 == $past(pwdata[7:0]))
    else $error("map14 write not stored");
  map13_write_a: assert property (s_write(hit_map13) |=> map13 == $past(pwdata[7:0]))
    else $error("map13 write not stored");
  map12_read_a: assert property (
    s_read_setup(hit_map12) |=> pready && prdata == {24'h0, map12})
    else $error("map12 readback wrong");
  class_prio_a: assert property (
    class_valid && in_slice |=> class_hit && class_prio == $past(prio_ref))
    else $error("classified priority does not match map field");
  class_order_a: assert property (
    class_valid && wr_done && hit_map15 |=> class_prio == $past(prio_ref))
    else $error("same-edge write leaked into classification");
  mld_enable_a: assert property (
    s_write(hit_ctrl21) |=> ##1 mld_snoop_en == $past(pwdata[2], 2))
    else $error("snoop enable not applied");
  mld_option_a: assert property (
    s_write(hit_ctrl21) |=> ##1 mld_snoop_option == $past(pwdata[3], 2))
    else $error("snoop option not applied");
  pass_all_gate_a: assert property (
    pass_all_frames == $past(rx_sniff_mirror & pass_all))
    else $error("pass-all output does not follow bit and receive sniffing");
  rsvd_slot_a: assert property (s_read_setup(hit_rsvd) |=> !pslverr && prdata == 32'h0)
    else $error("reserved port slot misbehaves");
  port4_map_a: assert property (s_write(hit_port4) |=> pass_all[3] == $past(pwdata[6]))
    else $error("port 4 control byte not at its slot");

  // map, classification and control storage
  map12_write_a: assert property (s_write(hit_map12) |=> map12 == $past(pwdata[7:0]))
    else $error("map12 write not stored");
  strobe_off_a: assert property (
    done && pwrite && !pstrb[0] |=> $stable(map_table))
    else $error("write without low lane strobe changed the map");
  class_miss_a: assert property (
    class_valid && !in_slice |=> !class_hit && class_prio == 2'h0)
    else $error("code point outside the slice gave a priority");
  class_hold_a: assert property (
    !class_valid |=> !class_done && $stable(class_hit) && $stable(class_prio))
    else $error("classification result moved without a frame");
  class_done_a: assert property (class_valid |=> class_done)
    else $error("classification not reported");
  snoop_read_a: assert property (
    s_read_setup(hit_ctrl21) |=> prdata[3:2] == $past({mld_opt, mld_en}))
    else $error("snoop controls read back wrong");
  ctrl21_hold_a: assert property (
    !(wr_done && hit_ctrl21) |=> $stable(mld_en) && $stable(mld_opt))
    else $error("snoop controls changed without a write");
  drive_write_a: assert property (
    s_write(hit_ctrl20) |=> ##1 hs_drive_strength == $past(pwdata[6:4], 2)
      && ls_drive_strength == $past(pwdata[2:0], 2))
    else $error("drive strength write not applied");
  port1_map_a: assert property (s_write(hit_port1) |=> pass_all[0] == $past(pwdata[6]))
    else $error("port 1 control byte not at its slot");
  port2_map_a: assert property (s_write(hit_port2) |=> pass_all[1] == $past(pwdata[6]))
    else $error("port 2 control byte not at its slot");
  port3_map_a: assert property (s_write(hit_port3) |=> pass_all[2] == $past(pwdata[6]))
    else $error("port 3 control byte not at its slot");
  pass_all_hold_a: assert property (
    !(wr_done && |hit_port) |=> $stable(pass_all))
    else $error("pass-all bit changed without a write");

  // bus answer timing
  answer_next_a: assert property (setup |=> pready)
    else $error("no answer in the cycle after setup");
  answer_once_a: assert property (s_answered |=> !pready)
    else $error("answer held longer than one cycle");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");

endmodule : dpm_regs
`default_nettype wire

/* File: src/dpm_defs.svh */
`ifndef DPM_DEFS_SVH
`define DPM_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define DPM_IDX_MAP12 8'h9c
`define DPM_IDX_MAP13 8'h9d
`define DPM_IDX_MAP14 8'h9e
`define DPM_IDX_MAP15 8'h9f
`define DPM_IDX_CTRL20 8'ha3
`define DPM_IDX_CTRL21 8'ha4
`define DPM_IDX_PORT1 8'hb0
`define DPM_IDX_PORT2 8'hc0
`define DPM_IDX_PORT3 8'hd0
`define DPM_IDX_RSVD 8'he0
`define DPM_IDX_PORT4 8'hf0

// reset values
`define DPM_MAP_RESET 8'h00
`define DPM_HS_DRIVE_RESET 3'h6
`define DPM_LS_DRIVE_RESET 3'h2
`define DPM_CTRL21_RSVD_HI 4'h2
`define DPM_CTRL21_RSVD_LO 2'h2
`define DPM_PORT_RSVD_B7 1'h1

// field positions
`define DPM_HS_DRIVE_LSB 4
`define DPM_LS_DRIVE_LSB 0
`define DPM_MLD_EN_BIT 2
`define DPM_MLD_OPT_BIT 3
`define DPM_PASS_ALL_BIT 6

// first code point held in this slice of the map
`define DPM_DSCP_BASE 6'h30

`endif

/* File: src/dpm_pkg.sv */
package dpm_pkg;
  typedef enum logic [0:0] {
    DPM_IDLE = 1'b0,
    DPM_ANSWER = 1'b1
  } dpm_apb_state_t;
  typedef logic [1:0] dpm_prio_t;
  typedef logic [7:0] dpm_byte_t;
endpackage : dpm_pkg

/* File: src/dpm_classify.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"

module dpm_classify (
  input wire logic [31:0] map_table,
  input wire logic [7:0] class_byte,
  output logic hit,
  output dpm_pkg::dpm_prio_t prio
);

  function automatic dpm_pkg::dpm_prio_t field_of(input logic [31:0] tbl, input logic [3:0] idx);
    field_of = tbl[{idx, 1'b0} +: 2];
  endfunction : field_of

  // only the code points 0x30..0x3f live here; lower ones belong to another bank
  wire [5:0] code_point = class_byte[7:2];
  assign hit = (code_point >= `DPM_DSCP_BASE);
  assign prio = hit ? field_of(map_table, code_point[3:0]) : 2'h0;

endmodule : dpm_classify
`default_nettype wire

/* File: test/dpm_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "dpm_defs.svh"

module dpm_regs_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, class_valid = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0, rx_sniff_mirror = '0;
  logic [7:0] ip_service_class_byte = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, class_done, class_hit, mld_snoop_en, mld_snoop_option, err;
  dpm_pkg::dpm_prio_t class_prio;
  logic [2:0] hs_drive_strength, ls_drive_strength;
  logic [3:0] pass_all_frames, pass_exp;
  logic [7:0] mdl [4];
  logic [7:0] pidx [4] = '{`DPM_IDX_PORT1, `DPM_IDX_PORT2, `DPM_IDX_PORT3, `DPM_IDX_PORT4};
  logic [7:0] d;
  int fails = 0, n_compared = 0;

  always #5 pclk = ~pclk;

  dpm_regs dpm_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .class_valid(class_valid),
    .ip_service_class_byte(ip_service_class_byte), .class_done(class_done),
    .class_hit(class_hit), .class_prio(class_prio), .mld_snoop_en(mld_snoop_en),
    .mld_snoop_option(mld_snoop_option), .hs_drive_strength(hs_drive_strength),
    .ls_drive_strength(ls_drive_strength), .rx_sniff_mirror(rx_sniff_mirror),
    .pass_all_frames(pass_all_frames));

  // {hit, prio}; code points below the slice are classified elsewhere
  function automatic logic [2:0] want_cls(input logic [7:0] b);
    logic [5:0] c;
    logic [7:0] m;
    c = b[7:2];
    m = mdl[c[3:2]];
    if (c < 6'h30) return 3'b000;
    return {1'b1, m[c[1:0]*2 +: 2]};
  endfunction : want_cls

  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // leading edge keeps the release of the previous transfer in its own time step
  task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] st);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      $display("[ERR] pready expected 1 seen timeout");
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 4'h0);
    chk(nm, {24'h0, exp}, rd);
    chk("pslverr", 32'h0, {31'h0, err});
  endtask : rchk

  task cls(input logic [7:0] b);
    @(posedge pclk);
    class_valid <= 1'b1;
    ip_service_class_byte <= b;
    @(posedge pclk);
    class_valid <= 1'b0;
    #1 chk("class", {28'h0, 1'b1, want_cls(b)}, {28'h0, class_done, class_hit, class_prio});
  endtask : cls

  initial begin
    void'($urandom(32'h22d9));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      mdl[k] = 8'h00;
      rchk("map", `DPM_IDX_MAP12 + 8'(k), `DPM_MAP_RESET);
      rchk("port", pidx[k], 8'h80);
    end
    rchk("drive", `DPM_IDX_CTRL20, 8'h62);
    rchk("snoop", `DPM_IDX_CTRL21, 8'h22);
    chk("drv out", 32'h32, {26'h0, hs_drive_strength, ls_drive_strength});
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      mdl[k] = d;
      apb(1'b1, `DPM_IDX_MAP12 + 8'(k), d, 4'h1);
      apb(1'b1, `DPM_IDX_MAP12 + 8'(k), ~d, 4'he);
      rchk("map", `DPM_IDX_MAP12 + 8'(k), d);
    end
    for (int c = 0; c < 64; c++) cls({6'(c), 2'($urandom)});
    d = {~mdl[3][7:6], 6'($urandom)};
    @(posedge pclk);
    class_valid <= 1'b1;
    ip_service_class_byte <= 8'hfc;
    apb(1'b1, `DPM_IDX_MAP15, d, 4'h1);
    #1 chk("class same edge", {30'h0, mdl[3][7:6]}, {30'h0, class_prio});
    mdl[3] = d;
    cls(8'hfc);
    $display("priority map done");
    repeat (4) begin
      d = 8'($urandom);
      apb(1'b1, `DPM_IDX_CTRL21, d, 4'h1);
      rchk("snoop", `DPM_IDX_CTRL21, {4'h2, d[3:2], 2'b10});
      chk("mld out", {30'h0, d[3:2]}, {30'h0, mld_snoop_option, mld_snoop_en});
      apb(1'b1, `DPM_IDX_CTRL20, d, 4'h1);
      rchk("drive", `DPM_IDX_CTRL20, {1'b0, d[6:4], 1'b0, d[2:0]});
      chk("drv out", {26'h0, d[6:4], d[2:0]}, {26'h0, hs_drive_strength, ls_drive_strength});
    end
    $display("global control done");
    repeat (3) begin
      for (int k = 0; k < 4; k++) begin
        d = 8'($urandom);
        pass_exp[k] = d[6];
        apb(1'b1, pidx[k], d, 4'h1);
        rchk("port", pidx[k], {1'b1, d[6], 6'h00});
      end
      rx_sniff_mirror <= 4'($urandom);
      repeat (2) @(posedge pclk);
      #1 chk("pass all", {28'h0, pass_exp & rx_sniff_mirror}, {28'h0, pass_all_frames});
    end
    apb(1'b1, `DPM_IDX_RSVD, 8'hff, 4'h1);
    rchk("reserved", `DPM_IDX_RSVD, 8'h00);
    apb(1'b0, 8'h01, 8'h00, 4'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("ports and errors done");
    give_verdict();
  end
endmodule : dpm_regs_test

`default_nettype wire
